// ===== design/spdf_port.sv
`timescale 1ns/100ps
`include "spdf_params.svh"
// Overview of operation
// - Rates 300 to 9600 baud selectable; 9600 after reset.
// - Formats 8 data no parity, 7 even (default), 7 odd.
// - Every frame starts with exactly one start bit.
// - Every frame ends with exactly two stop bits; the receiver checks only the first stop bit.
// - Frame spans start through last stop; rate and format as configured.
// - Ready drops at 100 buffered characters, returns when space frees.
// - Processed query plus line feed holds ready low until response sent.
// - Set-ready sampled before each character; false suspends output.
// - Ready held low while output is suspended by set-ready.
// - Break-in character aborts operation and discards pending output.
// - Local command makes every front-panel key work.
// - Remote command disables all keys except the local key.
// - Lockout command disables every key including local.
// - Carriage return plus line feed also terminates a command.
module spdf_port #(
  parameter int CLK_HZ = `SPDF_CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial line and handshake
  input wire logic rxd,
  output logic txd,
  output logic dtr,
  input wire logic dsr,
  // Instrument side
  output logic dev_clear,
  output logic keys_en,
  output logic local_key_en,
  output spdf_pkg::spdf_mode_t op_mode
);
  import spdf_pkg::*;

  spdf_port_st_t s;
  spdf_port_st_t n;
  logic os_tick;
  logic take;
  logic push;
  logic pop;
  logic rx_done;
  logic rx_bad;
  logic [7:0] rx_byte;
  logic [9:0] rx_fr;
  logic susp;
  logic arm_wr;
  logic clr_err;
  logic lf_now;
  logic arm;
  logic lfs;
  logic [7:0] mem_rdata;

  // Parity bit over seven data bits
  function automatic logic par_bit(input logic [6:0] d, input spdf_fmt_t f);
    return (f == SPDF_FMT_7O) ? ~^d : ^d;
  endfunction

  // Eleven-bit frame, sent from bit 0
  function automatic logic [10:0] tx_frame(input logic [7:0] c, input spdf_fmt_t f);
    logic b8;
    b8 = (f == SPDF_FMT_8N) ? c[7] : par_bit(c[6:0], f);
    return {2'b11, b8, c[6:0], 1'b0};
  endfunction

  spdf_baud_gen #(.CLK_HZ(CLK_HZ)) u_baud (
    .clk(clk),
    .sys_rst(sys_rst),
    .baud_sel(s.baud),
    .os_tick(os_tick)
  );

  spdf_rx_mem u_mem (
    .clk(clk),
    .sys_rst(sys_rst),
    .we(push),
    .waddr(s.wp),
    .wdata(rx_byte),
    .re(pop),
    .raddr(s.rp),
    .rdata(mem_rdata)
  );

  // Next-state logic for bus, transmitter, receiver and flow control
  always_comb begin
    n = s;
    n.dev_clr = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    rx_done = 1'b0;
    arm_wr = 1'b0;
    clr_err = 1'b0;
    lf_now = 1'b0;
    rx_fr = {rxd, s.rx_sh[9:1]};
    rx_byte = (s.fmt == SPDF_FMT_8N) ? rx_fr[8:1] : {1'b0, rx_fr[7:1]};
    rx_bad = !rx_fr[9] || (s.fmt != SPDF_FMT_8N && rx_fr[8] != par_bit(rx_fr[7:1], s.fmt));
    susp = s.tx_st == SPDF_TX_IDLE && s.tx_full && !dsr;
    take = hsel && htrans[1] && hready;
    // Address phase: capture and read
    n.dph_v = take;
    n.dph_w = hwrite;
    n.dph_a = haddr[7:0];
    if (take && !hwrite) begin
      case (haddr[7:0])
        `SPDF_CTRL_OFS: n.rdat = {23'h0, s.armed, 3'h0, s.fmt, s.baud};
        `SPDF_STAT_OFS: n.rdat = {16'h0, s.cnt, s.armed, s.cnt == 8'h0, s.rx_err,
                                  s.resp_hold, s.tx_st == SPDF_TX_SEND, s.tx_full, dsr, s.dtr};
        `SPDF_RXD_OFS: begin
          n.rdat = {23'h0, s.cnt != 8'h0, 8'h0};
          pop = s.cnt != 8'h0;
        end
        `SPDF_MODE_OFS: n.rdat = {30'h0, s.mode};
        default: n.rdat = 32'h0;
      endcase
    end
    // Data phase: writes
    if (s.dph_v && s.dph_w) begin
      case (s.dph_a)
        `SPDF_CTRL_OFS: begin
          n.baud = hwdata[2:0];
          if (hwdata[4:3] != 2'h3) begin
            n.fmt = spdf_fmt_t'(hwdata[4:3]);
          end
          arm_wr = hwdata[`SPDF_ARM_BIT];
        end
        `SPDF_STAT_OFS: clr_err = hwdata[`SPDF_ERR_BIT];
        `SPDF_TXD_OFS: begin
          if (!s.tx_full) begin
            n.tx_full = 1'b1;
            n.tx_char = hwdata[7:0];
            n.tx_last = hwdata[`SPDF_LAST_BIT];
          end
        end
        `SPDF_MODE_OFS: begin
          case (hwdata[1:0])
            2'h0: n.mode = SPDF_LOCAL;
            2'h1: n.mode = SPDF_REMOTE;
            2'h2: n.mode = SPDF_LOCKOUT;
            default: n.mode = s.mode;
          endcase
        end
        default: n.mode = s.mode;
      endcase
    end
    // Transmitter
    case (s.tx_st)
      SPDF_TX_IDLE: begin
        n.txd = 1'b1;
        if (s.tx_full && dsr) begin
          n.tx_sh = tx_frame(s.tx_char, s.fmt);
          n.txd = 1'b0;
          n.tx_st = SPDF_TX_SEND;
          n.tx_os = 4'h0;
          n.tx_bit = 4'h0;
          n.tx_full = 1'b0;
          n.tx_end_last = s.tx_last;
        end
      end
      SPDF_TX_SEND: begin
        if (os_tick) begin
          n.tx_os = s.tx_os + 4'h1;
          if (s.tx_os == 4'hf) begin
            if (s.tx_bit == `SPDF_FRAME_LAST) begin
              n.tx_st = SPDF_TX_IDLE;
              n.txd = 1'b1;
              if (s.tx_end_last) begin
                n.resp_hold = 1'b0;
              end
            end else begin
              n.tx_bit = s.tx_bit + 4'h1;
              n.tx_sh = {1'b1, s.tx_sh[10:1]};
              n.txd = s.tx_sh[1];
            end
          end
        end
      end
      default: n.tx_st = SPDF_TX_IDLE;
    endcase
    // Receiver, sampling mid-bit
    case (s.rx_st)
      SPDF_RX_IDLE: begin
        if (os_tick && !rxd) begin
          n.rx_st = SPDF_RX_SHIFT;
          n.rx_os = 4'h1;
          n.rx_bit = 4'h0;
        end
      end
      SPDF_RX_SHIFT: begin
        if (os_tick) begin
          n.rx_os = s.rx_os + 4'h1;
          if (s.rx_os == `SPDF_MID_OVS) begin
            if (s.rx_bit == 4'h0 && rxd) begin
              n.rx_st = SPDF_RX_IDLE;
            end else if (s.rx_bit == `SPDF_RX_LAST) begin
              n.rx_st = SPDF_RX_IDLE;
              rx_done = 1'b1;
            end else begin
              n.rx_sh = rx_fr;
              n.rx_bit = s.rx_bit + 4'h1;
            end
          end
        end
      end
      default: n.rx_st = SPDF_RX_IDLE;
    endcase
    // Received character handling
    if (rx_done && !rx_bad && rx_byte == `SPDF_CC_CHAR) begin
      n.dev_clr = 1'b1;
      n.tx_full = 1'b0;
      n.tx_st = SPDF_TX_IDLE;
      n.txd = 1'b1;
      n.armed = 1'b0;
      n.lf_seen = 1'b0;
      n.resp_hold = 1'b0;
    end else if (rx_done && !rx_bad && s.cnt != 8'h80) begin
      push = 1'b1;
      lf_now = rx_byte == `SPDF_LF_CHAR;
    end
    n.rx_err = (s.rx_err && !clr_err) || (rx_done && (rx_bad || s.cnt == 8'h80));
    if (push) begin
      n.wp = s.wp + 7'h1;
    end
    if (pop) begin
      n.rp = s.rp + 7'h1;
    end
    n.cnt = s.cnt + {7'h0, push} - {7'h0, pop};
    // Query response hold, set wins over end-of-reply clear, break-in clear wins over set
    arm = (s.armed || arm_wr) && !n.dev_clr;
    lfs = (s.lf_seen || lf_now) && !n.dev_clr;
    if (arm && lfs) begin
      n.resp_hold = 1'b1;
      n.armed = 1'b0;
      n.lf_seen = 1'b0;
    end else begin
      n.armed = arm;
      n.lf_seen = lfs;
    end
    n.dtr = n.cnt < `SPDF_FULL_LVL && !n.resp_hold && !susp;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.baud <= `SPDF_BAUD_RST;
      s.fmt <= spdf_fmt_t'(`SPDF_FMT_RST);
      s.txd <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Port drive
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = (s.dph_a == `SPDF_RXD_OFS && s.rdat[8]) ? {s.rdat[31:8], mem_rdata} : s.rdat;
  assign txd = s.txd;
  assign dtr = s.dtr;
  assign dev_clear = s.dev_clr;
  assign keys_en = s.mode == SPDF_LOCAL;
  assign local_key_en = s.mode != SPDF_LOCKOUT;
  assign op_mode = s.mode;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_cc_rx;
    rx_done && !rx_bad && rx_byte == `SPDF_CC_CHAR;
  endsequence
  sequence s_cleared;
    !s.tx_full && !s.resp_hold && s.dev_clr && s.txd;
  endsequence
  sequence s_tx_go;
    s.tx_st == SPDF_TX_IDLE ##1 s.tx_st == SPDF_TX_SEND;
  endsequence

  AST_CC_CLEAR: assert property (s_cc_rx |=> s_cleared)
    else $error("break-in did not clear output");
  AST_CC_NOPUSH: assert property (s_cc_rx and !pop |=> s.cnt == $past(s.cnt))
    else $error("break-in stored in buffer");
  AST_DTR_FULL: assert property (s.cnt >= `SPDF_FULL_LVL |-> !s.dtr)
    else $error("ready high with full buffer");
  AST_DTR_RESP: assert property (s.resp_hold |-> !s.dtr)
    else $error("ready high while response pending");
  AST_LF_HOLD: assert property (s.armed && lf_now && !n.dev_clr |=> s.resp_hold)
    else $error("line feed did not start response hold");
  AST_DTR_SUSP: assert property (susp |=> !s.dtr)
    else $error("ready high while output suspended");
  AST_DSR_HOLD: assert property (s.tx_st == SPDF_TX_IDLE && !dsr |=> s.tx_st == SPDF_TX_IDLE)
    else $error("character started with set-ready false");
  AST_START: assert property (s_tx_go |-> !s.txd)
    else $error("frame did not open with start bit");
  AST_STOP2: assert property (s.tx_st == SPDF_TX_SEND && s.tx_bit >= 4'h9 |-> s.txd)
    else $error("stop bit low");
  AST_RST_DFLT: assert property ($fell(sys_rst) |-> s.baud == 3'h5 && s.fmt == SPDF_FMT_7E)
    else $error("wrong defaults after reset");
  AST_LOCKOUT: assert property (s.mode == SPDF_LOCKOUT |-> !keys_en && !local_key_en)
    else $error("keys live in lockout");
  AST_REMOTE: assert property (s.mode == SPDF_REMOTE |-> !keys_en && local_key_en)
    else $error("remote key enables wrong");
  AST_LOCAL: assert property (s.mode == SPDF_LOCAL |-> keys_en && local_key_en)
    else $error("local key enables wrong");
endmodule

// ===== design/spdf_params.svh
`ifndef SPDF_PARAMS_SVH
`define SPDF_PARAMS_SVH
// Clock rate and oversampling
`define SPDF_CLK_HZ 20000000
`define SPDF_OVS 16
// Reset values
`define SPDF_BAUD_RST 3'h5
`define SPDF_FMT_RST 2'h1
// Input buffer geometry and hold-off level
`define SPDF_FIFO_AW 7
`define SPDF_FULL_LVL 8'h64
// Frame: start, 8 payload bits, 2 stop bits
`define SPDF_FRAME_LAST 4'ha
`define SPDF_RX_LAST 4'h9
`define SPDF_MID_OVS 4'h7
// Special characters
`define SPDF_CC_CHAR 8'h03
`define SPDF_LF_CHAR 8'h0a
// Register offsets
`define SPDF_CTRL_OFS 8'h00
`define SPDF_STAT_OFS 8'h04
`define SPDF_TXD_OFS 8'h08
`define SPDF_RXD_OFS 8'h0c
`define SPDF_MODE_OFS 8'h10
// Field positions
`define SPDF_ARM_BIT 8
`define SPDF_LAST_BIT 8
`define SPDF_ERR_BIT 5
`endif

// ===== design/spdf_pkg.sv
package spdf_pkg;
  typedef enum logic [1:0] {SPDF_FMT_8N, SPDF_FMT_7E, SPDF_FMT_7O} spdf_fmt_t;
  typedef enum logic [1:0] {SPDF_LOCAL, SPDF_REMOTE, SPDF_LOCKOUT} spdf_mode_t;
  typedef enum logic {SPDF_TX_IDLE, SPDF_TX_SEND} spdf_tx_st_t;
  typedef enum logic {SPDF_RX_IDLE, SPDF_RX_SHIFT} spdf_rx_st_t;
  typedef struct packed {
    logic [2:0] baud;
    spdf_fmt_t fmt;
    spdf_mode_t mode;
    logic dph_v;
    logic dph_w;
    logic [7:0] dph_a;
    logic [31:0] rdat;
    logic tx_full;
    logic [7:0] tx_char;
    logic tx_last;
    spdf_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_os;
    logic [3:0] tx_bit;
    logic tx_end_last;
    logic txd;
    spdf_rx_st_t rx_st;
    logic [3:0] rx_os;
    logic [3:0] rx_bit;
    logic [9:0] rx_sh;
    logic [6:0] wp;
    logic [6:0] rp;
    logic [7:0] cnt;
    logic rx_err;
    logic armed;
    logic lf_seen;
    logic resp_hold;
    logic dtr;
    logic dev_clr;
  } spdf_port_st_t;
endpackage

// ===== design/spdf_baud_gen.sv
`timescale 1ns/100ps
`include "spdf_params.svh"
module spdf_baud_gen #(
  parameter int CLK_HZ = `SPDF_CLK_HZ
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Rate select and oversample enable
  input wire logic [2:0] baud_sel,
  output logic os_tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } spdf_bg_st_t;

  spdf_bg_st_t s_reg;
  spdf_bg_st_t s_next;

  // Clocks per oversample tick for a rate code
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int rate;
    case (sel)
      3'h0: rate = 300;
      3'h1: rate = 600;
      3'h2: rate = 1200;
      3'h3: rate = 2400;
      3'h4: rate = 4800;
      default: rate = 9600;
    endcase
    return 16'(CLK_HZ / (`SPDF_OVS * rate));
  endfunction

  // Divider reloads on reaching the rate count
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (s_reg.cnt + 16'h1 >= baud_div(baud_sel)) begin
      s_next.cnt = 16'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 16'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign os_tick = s_reg.tick;
endmodule

// ===== design/spdf_rx_mem.sv
`timescale 1ns/100ps
`include "spdf_params.svh"
module spdf_rx_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Write side
  input wire logic we,
  input wire logic [`SPDF_FIFO_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read side, data held until next read
  input wire logic re,
  input wire logic [`SPDF_FIFO_AW-1:0] raddr,
  output logic [7:0] rdata
);
  typedef struct packed {
    logic [(1<<`SPDF_FIFO_AW)-1:0][7:0] mem;
    logic [7:0] rd;
  } spdf_mem_st_t;

  spdf_mem_st_t s_reg;
  spdf_mem_st_t s_next;

  // Store and registered fetch
  always_comb begin
    s_next = s_reg;
    if (we) begin
      s_next.mem[waddr] = wdata;
    end
    if (re) begin
      s_next.rd = s_reg.mem[raddr];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rd;
endmodule

// ===== bench/spdf_host_model.sv
`timescale 1ns/100ps
module spdf_host_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  clk,
  // Serial lines
  rxd,
  txd,
  // Handshake
  dtr,
  dsr
);
  input wire logic clk;
  output logic rxd;
  input wire logic txd;
  input wire logic dtr;
  output logic dsr;
  logic [10:0] got_q[$];
  logic [10:0] fr;
  int ri;

  // Idle line, host ready
  initial begin
    rxd = 1'b1;
    dsr = 1'b1;
  end

  // Send one frame; barge skips the ready wait for break-in
  task automatic send(input logic [10:0] f, input logic barge);
    while (!barge && dtr !== 1'b1) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask

  // Host set-ready level
  task automatic set_dsr(input logic v);
    dsr <= v;
    @(posedge clk);
  endtask

  // Collect device frames, sampled mid-bit, start bit first
  always begin
    @(posedge clk);
    if (txd === 1'b0) begin
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (ri = 0; ri < 11; ri++) begin
        fr[ri] = txd;
        if (ri < 10) repeat (BIT_CLKS) @(posedge clk);
      end
      got_q.push_back(fr);
    end
  end
endmodule

// ===== bench/serial_port_dtr_dsr_flow_tb_top.sv
`timescale 1ns/100ps
`include "spdf_params.svh"
module serial_port_dtr_dsr_flow_tb_top;
  import spdf_pkg::*;
  logic clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, rxd, txd, dtr, dsr;
  logic dev_clear, keys_en, local_key_en;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  spdf_mode_t op_mode;
  int bad_count, num_checks, clr_seen, n, k, dv;
  int mw[4] = '{1, 2, 3, 0};
  int me[4] = '{1, 2, 2, 0};
  int ke[4] = '{1, 0, 0, 3};
  logic [1:0] fl[3] = '{2'h0, 2'h2, 2'h1};

  // Single slave drives the bus ready
  assign hready = hreadyout;

  spdf_port #(.CLK_HZ(153600)) dut_u (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxd(rxd),
    .txd(txd), .dtr(dtr), .dsr(dsr), .dev_clear(dev_clear), .keys_en(keys_en),
    .local_key_en(local_key_en), .op_mode(op_mode));
  spdf_host_model #(.BIT_CLKS(16)) host_u (.clk(clk), .rxd(rxd), .txd(txd), .dtr(dtr),
    .dsr(dsr));

  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Count break-in pulses
  always @(posedge clk) if (dev_clear === 1'b1) clr_seen++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One single AHB-Lite transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hsize <= 3'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsize <= 3'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdv);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, rdv);
    chk(rdv, exp, what);
  endtask

  // Bounded wait for received frames
  task automatic wait_q(input int want);
    k = 0;
    while (host_u.got_q.size() < want && k < 5000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(host_u.got_q.size()), 32'(want), "frame count");
  endtask

  // Expected frame: start, 7 data LSB first, parity or d7, two stops
  function automatic logic [10:0] mkfr(input logic [1:0] f, input logic [7:0] c);
    logic p;
    p = (f == 2'h0) ? c[7] : ((f == 2'h1) ? ^c[6:0] : ~^c[6:0]);
    return {2'b11, p, c[6:0], 1'b0};
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    results;
  end

  // Test sequence
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = 32'h0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rdc(`SPDF_CTRL_OFS, 32'h0000000d, "ctrl reset");
    chk({28'h0, hresp, dtr, keys_en, local_key_en}, 32'h7, "reset levels");
    for (int i = 0; i < 4; i++) begin
      wr(`SPDF_MODE_OFS, 32'(mw[i]));
      repeat (2) @(posedge clk);
      chk({30'h0, op_mode}, 32'(me[i]), "mode");
      chk({30'h0, keys_en, local_key_en}, 32'(ke[i]), "keys");
      rdc(`SPDF_MODE_OFS, 32'(me[i]), "mode reg");
    end
    wr(`SPDF_MODE_OFS, 32'h1);
    $display("test modes finished");
    for (int b = 0; b < 6; b++) begin
      dv = 32 >> b;
      wr(`SPDF_CTRL_OFS, {27'h1, 3'(b)});
      wr(`SPDF_TXD_OFS, 32'h1);
      k = 0;
      while (txd !== 1'b0 && k < 100) begin
        @(posedge clk);
        k++;
      end
      n = 1;
      while (txd === 1'b0 && n < 9000) begin
        @(posedge clk);
        n++;
      end
      // First counted tick lands anywhere in the first tick period
      chk(32'(n >= 15 * dv + 2 && n <= 16 * dv + 1), 32'h1, "start bit width");
      repeat (192 * dv) @(posedge clk);
    end
    host_u.got_q.delete();
    $display("test rates finished");
    for (int i = 0; i < 3; i++) begin
      wr(`SPDF_CTRL_OFS, {27'h0, fl[i], 3'h5});
      wr(`SPDF_TXD_OFS, 32'hb5);
      wait_q(1);
      repeat (16) @(posedge clk);
      chk(32'(host_u.got_q.pop_front()), 32'(mkfr(fl[i], 8'hb5)), "tx frame");
      host_u.send(mkfr(fl[i], 8'hb5), 1'b0);
      rdc(`SPDF_RXD_OFS, (fl[i] == 2'h0) ? 32'h1b5 : 32'h135, "rx format");
    end
    host_u.send(mkfr(2'h1, 8'h5a), 1'b0);
    rdc(`SPDF_RXD_OFS, 32'h15a, "rx char");
    rdc(`SPDF_RXD_OFS, 32'h0, "rx empty");
    // Flipped parity bit: dropped and flagged, then flag cleared
    host_u.send(mkfr(2'h1, 8'h5a) ^ 11'h100, 1'b0);
    rdc(`SPDF_STAT_OFS, 32'h63, "parity error");
    wr(`SPDF_STAT_OFS, 32'h20);
    rdc(`SPDF_STAT_OFS, 32'h43, "error cleared");
    $display("test frames finished");
    host_u.set_dsr(1'b0);
    wr(`SPDF_TXD_OFS, 32'h47);
    repeat (40) @(posedge clk);
    chk({30'h0, txd, dtr}, 32'h2, "suspended");
    host_u.set_dsr(1'b1);
    wait_q(1);
    repeat (16) @(posedge clk);
    chk(32'(host_u.got_q.pop_front()), 32'(mkfr(2'h1, 8'h47)), "resumed");
    $display("test suspend finished");
    wr(`SPDF_CTRL_OFS, 32'h10d);
    host_u.send(mkfr(2'h1, 8'h0d), 1'b0);
    host_u.send(mkfr(2'h1, `SPDF_LF_CHAR), 1'b0);
    repeat (4) @(posedge clk);
    chk({31'h0, dtr}, 32'h0, "query hold");
    rdc(`SPDF_RXD_OFS, 32'h10d, "cr");
    rdc(`SPDF_RXD_OFS, 32'h10a, "lf");
    wr(`SPDF_TXD_OFS, 32'h131);
    wait_q(1);
    chk({31'h0, dtr}, 32'h0, "hold in reply");
    repeat (16) @(posedge clk);
    chk({31'h0, dtr}, 32'h1, "hold released");
    chk(32'(host_u.got_q.pop_front()), 32'(mkfr(2'h1, 8'h31)), "reply");
    $display("test query finished");
    for (int i = 0; i < 100; i++) host_u.send(mkfr(2'h1, 8'h41), 1'b0);
    repeat (4) @(posedge clk);
    chk({31'h0, dtr}, 32'h0, "full holdoff");
    bus(1'b0, `SPDF_STAT_OFS, 32'h0, rdv);
    chk({24'h0, rdv[15:8]}, {24'h0, `SPDF_FULL_LVL}, "count");
    rdc(`SPDF_RXD_OFS, 32'h141, "first out");
    repeat (3) @(posedge clk);
    chk({31'h0, dtr}, 32'h1, "space freed");
    for (int i = 0; i < 99; i++) rdc(`SPDF_RXD_OFS, 32'h141, "drain");
    rdc(`SPDF_RXD_OFS, 32'h0, "drained");
    $display("test buffer finished");
    wr(`SPDF_CTRL_OFS, 32'h10d);
    host_u.send(mkfr(2'h1, `SPDF_LF_CHAR), 1'b0);
    repeat (4) @(posedge clk);
    host_u.set_dsr(1'b0);
    wr(`SPDF_TXD_OFS, 32'h55);
    host_u.send(mkfr(2'h1, `SPDF_CC_CHAR), 1'b1);
    repeat (4) @(posedge clk);
    chk(32'(clr_seen), 32'h1, "clear pulse");
    rdc(`SPDF_STAT_OFS, 32'h101, "after clear");
    host_u.set_dsr(1'b1);
    repeat (200) @(posedge clk);
    chk(32'(host_u.got_q.size()), 32'h0, "output discarded");
    $display("test break-in finished");
    results;
  end
endmodule
